// ==== rtl/accel_power_pkg.sv ====
// Shared constants and types for the accelerometer power-mode control.
// Assumes a 200 MHz single clock and an AXI4-Lite register port with
// 8-bit byte addresses and 32-bit data.
`default_nettype none

package accel_power_pkg;

  // ===========================================================
  // Clock and rates
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned ODR_MAX_HZ = 3200;
  localparam int unsigned SLEEP_MAX_HZ = 8;
  localparam int unsigned ODR_MAX_CYCLES = CLK_HZ / ODR_MAX_HZ;
  localparam int unsigned SLEEP_MAX_CYCLES = CLK_HZ / SLEEP_MAX_HZ;

  // ===========================================================
  // Register indexes; byte address is four times the index
  localparam logic [5:0] IDX_INACT_THRESHOLD = 6'h25;
  localparam logic [5:0] IDX_INACT_TIME = 6'h26;
  localparam logic [5:0] IDX_RATE_POWER = 6'h2C;
  localparam logic [5:0] IDX_POWER_CONTROL = 6'h2D;
  localparam logic [5:0] IDX_MODE_STATUS = 6'h30;
  localparam int unsigned ADDR_W = 8;

  // ===========================================================
  // Field positions
  localparam int unsigned RATE_CODE_LSB = 0;
  localparam int unsigned LOW_POWER_BIT = 4;
  localparam int unsigned WAKEUP_LSB = 0;
  localparam int unsigned MEASURE_BIT = 3;
  localparam int unsigned AUTO_SLEEP_BIT = 4;
  localparam int unsigned LINK_BIT = 5;

  // ===========================================================
  // Rate codes and reset values
  localparam logic [3:0] RATE_CODE_MAX = 4'hF;
  localparam logic [3:0] RATE_CODE_MIN = 4'h6;
  localparam logic [3:0] LP_CODE_LO = 4'h7;
  localparam logic [3:0] LP_CODE_HI = 4'hC;
  localparam logic [7:0] RST_INACT_THRESHOLD = 8'h00;
  localparam logic [7:0] RST_INACT_TIME = 8'h00;
  localparam logic [7:0] RST_RATE_POWER = 8'h0A;
  localparam logic [7:0] RST_POWER_CONTROL = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ===========================================================
  // Types
  typedef enum logic [1:0] {MODE_STANDBY, MODE_MEASURE, MODE_SLEEP} mode_t;
  typedef enum logic [2:0] {
    SEL_THRESH, SEL_TIME, SEL_RATE, SEL_PCTL, SEL_STAT, SEL_NONE
  } reg_sel_t;

  // Power status presented to the sensing logic
  typedef struct packed {
    logic sensing_enable;
    logic sleep_active;
    logic low_power_active;
  } pm_status_t;

endpackage

`default_nettype wire

// ==== rtl/accel_power_mode_control.sv ====
// Power-mode control: standby / measure / sleep sequencing, output data
// rate strobes and the configuration registers behind an AXI4-Lite port.
// Assumes motion detection outside drives the inactivity/activity pulses
// and that the sample FIFO and sensing element live elsewhere.
//
// Contract
// - After reset the block sits in standby with sensing off until commanded.
// - Setting the measure bit of the power control register starts measurement.
// - Clearing the measure bit, bit 3, returns the block to standby.
// - All registers stay readable and writable while in standby; the mode status register is read-only here.
// - In standby no samples are taken and all sensing is off.
// - Once measurement is commanded all sensing functions are enabled.
// - Going to standby never clears or flushes the sample FIFO.
// - A four-bit rate code picks the output rate, 1111 = 3200 Hz, halving to 0110.
// - Bit 4 of the rate register turns low power mode on and off.
// - Low power lowers internal sampling for rate codes 0111 to 1100.
// - With auto-sleep on, inactivity moves the block to sleep at 8 Hz or below.
//
// Design decision made here: register access over AXI4-Lite.
`default_nettype none

module accel_power_mode_control
  import accel_power_pkg::*;
#(
  parameter int unsigned ODR_BASE_CYCLES = ODR_MAX_CYCLES,
  parameter int unsigned SLEEP_BASE_CYCLES = SLEEP_MAX_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Motion detector events
  input wire logic inactivity_detected,
  input wire logic activity_detected,
  // Power state, rate strobes and inactivity settings
  output pm_status_t pm_status,
  output logic sample_strobe,
  output logic internal_sample_strobe,
  output logic [7:0] inact_threshold,
  output logic [7:0] inact_time
);

  // ===========================================================
  // Decoding helpers

  // Word index of a byte address to a register select
  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    logic [5:0] idx;
    idx = addr[ADDR_W-1:2];
    case (idx)
      IDX_INACT_THRESHOLD: decode = SEL_THRESH;
      IDX_INACT_TIME: decode = SEL_TIME;
      IDX_RATE_POWER: decode = SEL_RATE;
      IDX_POWER_CONTROL: decode = SEL_PCTL;
      IDX_MODE_STATUS: decode = SEL_STAT;
      default: decode = SEL_NONE;
    endcase
  endfunction

  // Output data rate period in clock cycles for a rate code
  function automatic logic [31:0] odr_period(input logic [3:0] code);
    logic [3:0] c;
    logic [3:0] sh;
    c = (code < RATE_CODE_MIN) ? RATE_CODE_MIN : code;
    sh = RATE_CODE_MAX - c;
    odr_period = 32'(ODR_BASE_CYCLES) << sh;
  endfunction

  // Low power only pays inside the middle rate band; at the top and the
  // bottom codes the internal rate stays at twice the output rate
  function automatic logic lp_window(input logic [7:0] rate);
    logic [3:0] code;
    code = rate[RATE_CODE_LSB +: 4];
    lp_window = rate[LOW_POWER_BIT] && code >= LP_CODE_LO
      && code <= LP_CODE_HI;
  endfunction

  // ===========================================================
  // State

  typedef struct packed {
    mode_t mode;
    logic [7:0] thresh;
    logic [7:0] itime;
    logic [7:0] rate;
    logic [7:0] pctl;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] odr_cnt;
    logic [31:0] int_cnt;
    logic sample;
    logic int_sample;
    pm_status_t status;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // Period selection, shared by the counters
  logic [31:0] odr_cycles;
  logic [31:0] int_cycles;
  logic [3:0] rate_code;
  logic lp_saving;
  logic [1:0] wake_code;

  // Sleep runs at the wake-up rate; low power halves internal sampling.
  // Periods follow the committed registers, so a rate write takes hold
  // one cycle after its commit; the running count is not restarted.
  always_comb begin
    rate_code = st_r.rate[RATE_CODE_LSB +: 4];
    wake_code = st_r.pctl[WAKEUP_LSB +: 2];
    lp_saving = lp_window(st_r.rate);
    if (st_r.mode == MODE_SLEEP) begin
      odr_cycles = 32'(SLEEP_BASE_CYCLES) << wake_code;
      int_cycles = odr_cycles;
    end else begin
      odr_cycles = odr_period(rate_code);
      int_cycles = lp_saving ? odr_cycles : (odr_cycles >> 1);
    end
  end

  // ===========================================================
  // Next-state logic
  always_comb begin
    reg_sel_t wsel;
    reg_sel_t rsel;
    logic do_write;
    logic measure_bit;
    logic [7:0] wbyte;
    wsel = SEL_NONE;
    rsel = SEL_NONE;
    do_write = 1'b0;
    measure_bit = 1'b0;
    wbyte = 8'h00;
    st_nxt = st_r;

    // Write address and data may arrive in either order
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // Commit once both halves are held and no response is pending;
    // registers take writes in every mode, standby included.
    // Only byte lane 0 carries a register; a write without it is
    // acknowledged but leaves the register alone.
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      wsel = decode(st_r.aw_addr);
      wbyte = st_r.w_data[7:0];
      do_write = st_r.w_strb[0];
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = (wsel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
      if (do_write) begin
        case (wsel)
          SEL_THRESH: st_nxt.thresh = wbyte;
          SEL_TIME: st_nxt.itime = wbyte;
          SEL_RATE: st_nxt.rate = wbyte;
          SEL_PCTL: st_nxt.pctl = wbyte;
          default: ;
        endcase
      end
    end
    st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_got && !st_nxt.bvalid;

    // Reads answer one cycle after the address is taken; rdata and rresp
    // stay frozen until rready, and arready stays low meanwhile so a
    // second read cannot overwrite an answer not yet taken
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_r.arready) begin
      rsel = decode(s_axi_araddr);
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = (rsel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
      case (rsel)
        SEL_THRESH: st_nxt.rdata = {24'h000000, st_r.thresh};
        SEL_TIME: st_nxt.rdata = {24'h000000, st_r.itime};
        SEL_RATE: st_nxt.rdata = {24'h000000, st_r.rate};
        SEL_PCTL: st_nxt.rdata = {24'h000000, st_r.pctl};
        SEL_STAT: st_nxt.rdata = {29'h00000000, st_r.status.low_power_active,
          2'(st_r.mode)};
        default: st_nxt.rdata = 32'h00000000;
      endcase
    end
    st_nxt.arready = !st_nxt.rvalid;

    // Mode sequencing from the committed control register. The value
    // written in this cycle counts, so the mode moves at the same edge
    // as the write response. Clearing auto-sleep while asleep wakes the
    // block rather than leaving it stuck at the slow rate.
    measure_bit = st_nxt.pctl[MEASURE_BIT];
    case (st_r.mode)
      MODE_STANDBY: begin
        if (measure_bit) begin
          st_nxt.mode = MODE_MEASURE;
        end
      end
      MODE_MEASURE: begin
        if (!measure_bit) begin
          st_nxt.mode = MODE_STANDBY;
        end else if (st_nxt.pctl[AUTO_SLEEP_BIT] && inactivity_detected) begin
          st_nxt.mode = MODE_SLEEP;
        end
      end
      MODE_SLEEP: begin
        if (!measure_bit) begin
          st_nxt.mode = MODE_STANDBY;
        end else if (!st_nxt.pctl[AUTO_SLEEP_BIT]) begin
          st_nxt.mode = MODE_MEASURE;
        end else if (st_nxt.pctl[LINK_BIT] && activity_detected) begin
          st_nxt.mode = MODE_MEASURE;
        end
      end
      default: st_nxt.mode = MODE_STANDBY;
    endcase

    // Rate counters: held at zero in standby and restarted on
    // every mode change so each entry begins a full period at the new
    // rate instead of a stub left over from the old one
    st_nxt.sample = 1'b0;
    st_nxt.int_sample = 1'b0;
    if (st_r.mode == MODE_STANDBY || st_nxt.mode != st_r.mode) begin
      st_nxt.odr_cnt = 32'h00000000;
      st_nxt.int_cnt = 32'h00000000;
    end else begin
      // Selected rate is read live, so a resume needs no rewrite
      if (st_r.odr_cnt + 32'h00000001 >= odr_cycles) begin
        st_nxt.odr_cnt = 32'h00000000;
        st_nxt.sample = 1'b1;
      end else begin
        st_nxt.odr_cnt = st_r.odr_cnt + 32'h00000001;
      end
      if (st_r.int_cnt + 32'h00000001 >= int_cycles) begin
        st_nxt.int_cnt = 32'h00000000;
        st_nxt.int_sample = 1'b1;
      end else begin
        st_nxt.int_cnt = st_r.int_cnt + 32'h00000001;
      end
    end

    // Status seen by the sensing logic. There is deliberately no flush
    // or clear towards the sample FIFO: standby only gates sensing, so
    // stored samples survive any mode change. Low power is flagged from
    // the incoming rate value so the flag moves with the mode.
    st_nxt.status.sensing_enable = (st_nxt.mode != MODE_STANDBY);
    st_nxt.status.sleep_active = (st_nxt.mode == MODE_SLEEP);
    st_nxt.status.low_power_active = lp_window(st_nxt.rate)
      && (st_nxt.mode == MODE_MEASURE);
  end

  // ===========================================================
  // State register

  // Reset lands in standby with measurement off. The reset is sampled
  // on the clock like any other input, so it must be held for at least
  // one edge; the bus readies rise at the first edge after release.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r.mode <= MODE_STANDBY;
      st_r.thresh <= RST_INACT_THRESHOLD;
      st_r.itime <= RST_INACT_TIME;
      st_r.rate <= RST_RATE_POWER;
      st_r.pctl <= RST_POWER_CONTROL;
      st_r.aw_got <= 1'b0;
      st_r.w_got <= 1'b0;
      st_r.aw_addr <= '0;
      st_r.w_data <= 32'h00000000;
      st_r.w_strb <= 4'h0;
      st_r.awready <= 1'b0;
      st_r.wready <= 1'b0;
      st_r.bvalid <= 1'b0;
      st_r.bresp <= RESP_OKAY;
      st_r.arready <= 1'b0;
      st_r.rvalid <= 1'b0;
      st_r.rresp <= RESP_OKAY;
      st_r.rdata <= 32'h00000000;
      st_r.odr_cnt <= 32'h00000000;
      st_r.int_cnt <= 32'h00000000;
      st_r.sample <= 1'b0;
      st_r.int_sample <= 1'b0;
      st_r.status <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ===========================================================
  // Outputs, all straight from the state register; no output passes
  // through logic after the flop, so the far side sees clean timing
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = st_r.rdata;
  assign pm_status = st_r.status;
  assign sample_strobe = st_r.sample;
  assign internal_sample_strobe = st_r.int_sample;
  assign inact_threshold = st_r.thresh;
  assign inact_time = st_r.itime;

endmodule

`default_nettype wire

// ==== sim/accel_power_mode_control_chk.sv ====
// Checker for the power-mode control, port relations only.
// Assumes a bind from the bench top file handing on both parameters.
`default_nettype none
module accel_power_mode_control_chk
  import accel_power_pkg::*;
#(
  parameter int unsigned ODR_BASE_CYCLES = 8,
  parameter int unsigned SLEEP_BASE_CYCLES = 64
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Power state and rate strobes
  input wire pm_status_t pm_status,
  input wire logic sample_strobe,
  input wire logic internal_sample_strobe
);
  // ==========================================
  // Cycles since last output strobe
  int unsigned gap_r;
  always_ff @(posedge aclk) begin
    if (!aresetn || sample_strobe) gap_r <= 0;
    else if (gap_r < 32'h000F_FFFF) gap_r <= gap_r + 1;
  end

  // ==========================================
  // Relations; a saturating gap avoids wrap on long runs
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  stby_quiet_a: assert property (!pm_status.sensing_enable |->
    !sample_strobe && !internal_sample_strobe) else $error("standby strobe");
  odr_gap_a: assert property (sample_strobe |->
    gap_r + 1 >= ODR_BASE_CYCLES) else $error("strobes too close");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read not answered");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  rd_upper_a: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write response dropped");
  lp_meas_a: assert property (pm_status.low_power_active |->
    pm_status.sensing_enable && !pm_status.sleep_active)
    else $error("low power outside measure");
  sleep_entry_a: assert property ($rose(pm_status.sleep_active) |->
    $past(pm_status.sensing_enable)) else $error("sleep not from measure");
  sleep_gap_a: assert property (pm_status.sleep_active &&
    sample_strobe |-> gap_r + 1 >= SLEEP_BASE_CYCLES)
    else $error("sleep strobes too close");
endmodule
`default_nettype wire

// ==== sim/test_accel_power_mode_control.sv ====
// Bench for the power-mode control: bus tasks and mode scenarios.
// Assumes the package and the checker are compiled before this file.
`default_nettype none
module test_accel_power_mode_control
  import accel_power_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ODR = 8;
  localparam int SLP = 64;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic inactivity_detected = 1'b0, activity_detected = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, sample_strobe, internal_sample_strobe;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] inact_threshold, inact_time;
  pm_status_t pm_status;
  int n_errors = 0;
  int samples_checked = 0;
  int c;

  accel_power_mode_control #(.ODR_BASE_CYCLES(ODR), .SLEEP_BASE_CYCLES(SLP))
  accel_power_mode_control_inst (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .inactivity_detected, .activity_detected, .pm_status,
    .sample_strobe, .internal_sample_strobe, .inact_threshold, .inact_time);

  // ==========================================
  // Clock
  initial forever #2.5 aclk = ~aclk;

  // ==========================================
  // Compare, verdict and bounded-wait helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic tmo(input int i);
    if (i >= 9999) begin
      n_errors++;
      $display("[ERR] %0t wait expired", $time);
      test_done();
    end
  endtask
  function automatic logic strb(input bit s);
    return s ? internal_sample_strobe : sample_strobe;
  endfunction

  // ==========================================
  // Bus tasks; each half released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 9999; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    tmo(i);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er = RESP_OKAY);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 9999; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    tmo(i);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // Period between two strobes; first strobe after a change is skipped
  task automatic per(input bit s, input int exp);
    int i;
    for (i = 0; i < 9999 && strb(s) !== 1'b1; i++) @(posedge aclk);
    tmo(i);
    for (i = 1; i < 9999; i++) begin
      @(posedge aclk);
      if (strb(s) === 1'b1) break;
    end
    tmo(i);
    chk(i, exp);
  endtask

  // ==========================================
  // Scenarios
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({29'h0, pm_status}, 32'h0);
    rd(8'h94, 32'h0);
    rd(8'h98, 32'h0);
    rd(8'hB0, {24'h0, RST_RATE_POWER});
    rd(8'hB4, 32'h0);
    $display("test reset done");
    wr(8'h94, 8'h5A, RESP_OKAY);
    wr(8'h98, 8'h3C, RESP_OKAY);
    wr(8'hB0, 8'h0F, RESP_OKAY);
    wr(8'h00, 8'h11, RESP_DECERR);
    rd(8'hB0, 32'h0F);
    chk({24'h0, inact_threshold}, 32'h5A);
    chk({24'h0, inact_time}, 32'h3C);
    chk({29'h0, pm_status}, 32'h0);
    $display("test standby config done");
    wr(8'hB4, 8'h08, RESP_OKAY);
    @(posedge aclk);
    chk({29'h0, pm_status}, 32'h4);
    rd(8'hC0, 32'h1);
    wr(8'hB0, 8'h03, RESP_OKAY);
    per(1'b0, ODR << 9);
    for (c = 6; c < 16; c++) begin
      wr(8'hB0, c[7:0], RESP_OKAY);
      per(1'b0, ODR << (15 - c));
      per(1'b1, (ODR / 2) << (15 - c));
    end
    wr(8'hB0, 8'h1C, RESP_OKAY);
    @(posedge aclk);
    chk({29'h0, pm_status}, 32'h5);
    rd(8'hC0, 32'h5);
    per(1'b1, ODR << 3);
    wr(8'hB0, 8'h1F, RESP_OKAY);
    per(1'b1, ODR / 2);
    wr(8'hB0, 8'h0A, RESP_OKAY);
    @(posedge aclk);
    chk({29'h0, pm_status}, 32'h4);
    $display("test rates done");
    wr(8'hB4, 8'h00, RESP_OKAY);
    @(posedge aclk);
    chk({29'h0, pm_status}, 32'h0);
    rd(8'hC0, 32'h0);
    s_axi_wstrb <= 4'hE;
    wr(8'hB0, 8'h55, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(8'hB0, 32'h0A);
    wr(8'hB4, 8'h08, RESP_OKAY);
    per(1'b0, ODR << 5);
    $display("test reentry done");
    for (c = 0; c < 4; c++) begin
      wr(8'hB4, 8'h38 | c[7:0], RESP_OKAY);
      if (c == 0) begin
        inactivity_detected <= 1'b1;
        @(posedge aclk);
        inactivity_detected <= 1'b0;
        @(posedge aclk);
        @(posedge aclk);
      end
      chk({31'h0, pm_status.sleep_active}, 32'h1);
      rd(8'hC0, 32'h2);
      per(1'b0, SLP << c);
    end
    activity_detected <= 1'b1;
    @(posedge aclk);
    activity_detected <= 1'b0;
    @(posedge aclk);
    @(posedge aclk);
    chk({31'h0, pm_status.sleep_active}, 32'h0);
    wr(8'hB4, 8'h08, RESP_OKAY);
    inactivity_detected <= 1'b1;
    @(posedge aclk);
    inactivity_detected <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({31'h0, pm_status.sleep_active}, 32'h0);
    rd(8'h00, 32'h0, RESP_DECERR);
    $display("test auto sleep done");
    test_done();
  end
endmodule

bind accel_power_mode_control accel_power_mode_control_chk #(
  .ODR_BASE_CYCLES(ODR_BASE_CYCLES), .SLEEP_BASE_CYCLES(SLEEP_BASE_CYCLES)
) chk_inst (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pm_status,
  .sample_strobe, .internal_sample_strobe);
`default_nettype wire
